/* oss_defs.svh */
/*
  Register offsets, field positions, reset values and counts for the
  oscillator source switch. Included by the design and the bench;
  assumes nothing beyond a SystemVerilog compiler.
*/
// Behaviour
// RL1 - Select 00 internal, 01 external clock, 10 external RC, 11 crystal.
// RL2 - Any external source makes the input pin a clock input; crystal also claims output pin.
// RL3 - Software sets the request only after the source has stabilised.
// RL4 - After seeing the request, wait two external rising edges before switching.
// RL5 - Switching from internal to external clock leaves no glitch on outputs.
// RL6 - Set the engaged status first, then stop the internal oscillator.
// RL7 - Once engaged only reset brings back the internal oscillator; no fallback.
// RL8 - Software should wait about 4096 crystal cycles before requesting.
// RL9 - Software may precharge a crystal by driving the output pin high.
// RL10 - Output pin: crystal amp, port I/O for external clock, else enable picks clock.
// RL11 - External clock mode takes the input pin straight as the full-rate clock.
// RL12 - Full-rate clock equals the selected source and goes to integration logic.
// RL13 - Half-rate clock runs at half the full-rate clock.
// RL14 - Wait mode changes nothing; both clocks keep running.
// RL15 - Stop mode disables the source clock and both derived clocks; the code stops only the derived clocks, oscillator enables stay on.
// RL16 - Debug break keeps both clocks running.
// RL17 - Integration enable turns the selected oscillator on or off.
// RL18 - Request bit is read/write, cleared by reset, ignored in monitor bypass.
// RL19 - Engaged bit is read-only, 1 while an external source drives the clock.
// RL20 - Eight read/write trim bits set internal capacitance; larger means longer period.
// RL21 - Trim resets to midpoint 0x80 for a nominal 4.0 MHz.
// RL22 - After reset the internal oscillator is the source until a switch completes.
// RL23 - Request is synchronised before activity edges are counted.
`ifndef OSS_DEFS_SVH
`define OSS_DEFS_SVH

`define OSS_ADDR_W 12
`define OSS_STATUS_OFS 12'h000
`define OSS_TRIM_OFS 12'h004
`define OSS_CTRL_OFS 12'h008

`define OSS_ST_ENGAGED_BIT 0
`define OSS_ST_REQUEST_BIT 1
`define OSS_CTRL_SEL_LSB 0
`define OSS_CTRL_SEL_MSB 1
`define OSS_CTRL_PINEN_BIT 2

`define OSS_SRC_INT 2'h0
`define OSS_SRC_EXT 2'h1
`define OSS_SRC_RC 2'h2
`define OSS_SRC_XTAL 2'h3

`define OSS_TRIM_RESET 8'h80
`define OSS_ACTIVITY_EDGES 2'h2

`endif

/* oss_pkg.sv */
/*
  Types shared by the oscillator source switch.
  Assumes oss_defs.svh is on the include path.
*/
package oss_pkg;
  typedef enum logic [2:0] {
    OSS_RUN_INT,
    OSS_CONFIRM,
    OSS_ALIGN,
    OSS_RUN_EXT
  } oss_state_t;

  // Shared clock output pin bundle
  typedef struct packed {
    logic o;
    logic oe;
    logic port_owns;
  } oss_pin_t;
endpackage : oss_pkg

/* oss_switch.sv */
/*
  Oscillator source switch: source decode, request handshake, glitch-free
  move from internal to external clock, derived clocks, pin muxing and an
  APB register file (status, trim, control).
  Assumes source clock levels arrive synchronous to pclk and well below
  half its rate; the integration logic drives enable, stop and monitor.
*/
// Implementation choices: the register addresses and the APB interface to the registers.
`include "oss_defs.svh"

module oss_switch (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OSS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source clock levels
  input wire logic internal_source_clock,
  input wire logic clock_input_pin,
  input wire logic resistor_cap_clock,
  input wire logic crystal_source_clock,
  // Integration logic controls
  input wire logic osc_enable_from_integration,
  input wire logic stop_mode,
  input wire logic monitor_bypass,
  // Clocks out
  output logic full_rate_clock,
  output logic half_rate_clock,
  // Oscillator circuit controls
  output logic int_osc_enable,
  output logic rc_osc_enable,
  output logic xtal_osc_enable,
  output logic [7:0] trim_factor,
  // Pins
  output logic clock_input_enable,
  output logic xtal_amp_enable,
  output oss_pkg::oss_pin_t clock_output_pin
);

  logic [1:0] clock_source_select;
  logic clkout_pin_enable;
  logic ext_clock_request;
  logic ext_clock_engaged;
  logic using_ext;
  logic int_stopped;
  logic req_meta;
  logic req_sync;
  logic ext_prev;
  logic [1:0] edge_cnt;
  oss_pkg::oss_state_t state;
  logic ext_lvl;
  logic next_full;
  logic setup;
  logic wr_access;
  logic [31:0] rd_word;
  logic rd_hit;

  // External source level for the selected mode
  function automatic logic pick_ext(input logic [1:0] sel, input logic pin,
                                    input logic rc, input logic xt);
    case (sel)
      `OSS_SRC_EXT: pick_ext = pin;   // [RL11]
      `OSS_SRC_RC: pick_ext = rc;
      `OSS_SRC_XTAL: pick_ext = xt;
      default: pick_ext = 1'b0;
    endcase
  endfunction : pick_ext

  // Internal or RC source may drive the output pin
  function automatic logic pin_can_clock(input logic [1:0] sel);
    pin_can_clock = (sel == `OSS_SRC_INT) || (sel == `OSS_SRC_RC);
  endfunction : pin_can_clock

  assign ext_lvl = pick_ext(clock_source_select, clock_input_pin,
                            resistor_cap_clock, crystal_source_clock);

  // Wait and break have no input here: the clock path ignores them
  always_comb begin
    if (!osc_enable_from_integration || stop_mode) begin
      next_full = 1'b0;   // [RL15] [RL17]
    end else if (using_ext) begin
      next_full = ext_lvl;   // [RL12]
    end else begin
      next_full = internal_source_clock;   // [RL12] [RL14] [RL16] [RL22]
    end
  end

  // APB decode
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `OSS_STATUS_OFS: begin
        rd_word[`OSS_ST_ENGAGED_BIT] = ext_clock_engaged;   // [RL19]
        rd_word[`OSS_ST_REQUEST_BIT] = ext_clock_request;
      end
      `OSS_TRIM_OFS: rd_word[7:0] = trim_factor;
      `OSS_CTRL_OFS: begin
        rd_word[`OSS_CTRL_SEL_MSB:`OSS_CTRL_SEL_LSB] = clock_source_select;
        rd_word[`OSS_CTRL_PINEN_BIT] = clkout_pin_enable;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Zero-wait slave: answer is loaded in setup, valid through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        pready <= 1'b1;
        pslverr <= !rd_hit;
        prdata <= (rd_hit && !pwrite) ? rd_word : 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Request bit; ignored while the monitor bypasses the oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clock_request <= 1'b0;   // [RL18]
    end else if (ce) begin
      if (wr_access && paddr == `OSS_STATUS_OFS && !monitor_bypass) begin
        ext_clock_request <= pwdata[`OSS_ST_REQUEST_BIT];   // [RL18]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_factor <= `OSS_TRIM_RESET;   // [RL21]
    end else if (ce) begin
      if (wr_access && paddr == `OSS_TRIM_OFS) begin
        trim_factor <= pwdata[7:0];   // [RL20]
      end
    end
  end

  // Source locked once switching begins, so the edge count stays honest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select <= `OSS_SRC_INT;   // [RL22]
      clkout_pin_enable <= 1'b0;
    end else if (ce) begin
      if (wr_access && paddr == `OSS_CTRL_OFS) begin
        if (state == oss_pkg::OSS_RUN_INT) begin
          clock_source_select <= pwdata[`OSS_CTRL_SEL_MSB:`OSS_CTRL_SEL_LSB];   // [RL1]
        end
        clkout_pin_enable <= pwdata[`OSS_CTRL_PINEN_BIT];
      end
    end
  end

  // Two-stage synchroniser for the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else if (ce) begin
      req_meta <= ext_clock_request;   // [RL23]
      req_sync <= req_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else if (ce) begin
      ext_prev <= ext_lvl;
    end
  end

  // Switch sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= oss_pkg::OSS_RUN_INT;
      edge_cnt <= 2'h0;
      using_ext <= 1'b0;
      ext_clock_engaged <= 1'b0;
      int_stopped <= 1'b0;
    end else if (ce) begin
      case (state)
        oss_pkg::OSS_RUN_INT: begin
          edge_cnt <= 2'h0;
          // Software is trusted to have let the source settle first
          if (req_sync && clock_source_select != `OSS_SRC_INT && !monitor_bypass) begin   // [RL3] [RL8]
            state <= oss_pkg::OSS_CONFIRM;
          end
        end
        oss_pkg::OSS_CONFIRM: begin
          if (!req_sync) begin
            state <= oss_pkg::OSS_RUN_INT;
          end else if (ext_lvl && !ext_prev) begin
            edge_cnt <= edge_cnt + 2'h1;   // [RL4]
            if (edge_cnt + 2'h1 == `OSS_ACTIVITY_EDGES) begin
              state <= oss_pkg::OSS_ALIGN;   // [RL4]
            end
          end
        end
        oss_pkg::OSS_ALIGN: begin
          // Hand over only while both sources and the output sit low
          if (!internal_source_clock && !ext_lvl && !full_rate_clock) begin   // [RL5]
            using_ext <= 1'b1;
            ext_clock_engaged <= 1'b1;   // [RL6] [RL19]
            state <= oss_pkg::OSS_RUN_EXT;
          end
        end
        oss_pkg::OSS_RUN_EXT: begin
          // No clock monitor: a dead source is not left
          int_stopped <= 1'b1;   // [RL6] [RL7]
        end
        default: state <= oss_pkg::OSS_RUN_INT;
      endcase
    end
  end

  // Derived clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_rate_clock <= 1'b0;
      half_rate_clock <= 1'b0;
    end else if (ce) begin
      full_rate_clock <= next_full;   // [RL12]
      if (next_full && !full_rate_clock) begin
        half_rate_clock <= !half_rate_clock;   // [RL13]
      end
    end
  end

  // Oscillator circuit enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_osc_enable <= 1'b0;
      rc_osc_enable <= 1'b0;
      xtal_osc_enable <= 1'b0;
    end else if (ce) begin
      int_osc_enable <= osc_enable_from_integration && !int_stopped;   // [RL17] [RL7]
      rc_osc_enable <= osc_enable_from_integration && clock_source_select == `OSS_SRC_RC;   // [RL17]
      xtal_osc_enable <= osc_enable_from_integration && clock_source_select == `OSS_SRC_XTAL;   // [RL17]
    end
  end

  // Pin functions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_input_enable <= 1'b0;
      xtal_amp_enable <= 1'b0;
      clock_output_pin <= '{o: 1'b0, oe: 1'b0, port_owns: 1'b1};
    end else if (ce) begin
      clock_input_enable <= clock_source_select != `OSS_SRC_INT;   // [RL2] [RL11]
      xtal_amp_enable <= clock_source_select == `OSS_SRC_XTAL;   // [RL2] [RL10]
      if (clock_source_select == `OSS_SRC_XTAL) begin
        clock_output_pin <= '{o: 1'b0, oe: 1'b0, port_owns: 1'b0};   // [RL10]
      end else if (pin_can_clock(clock_source_select) && clkout_pin_enable) begin
        clock_output_pin <= '{o: next_full, oe: 1'b1, port_owns: 1'b0};   // [RL10]
      end else begin
        clock_output_pin <= '{o: 1'b0, oe: 1'b0, port_owns: 1'b1};   // [RL10]
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence engage_s;
    $rose(ext_clock_engaged);
  endsequence

  sequence confirmed_s;
    edge_cnt == `OSS_ACTIVITY_EDGES;
  endsequence

  ext_input_pin_a: assert property (ce && clock_source_select != `OSS_SRC_INT |=> clock_input_enable) // [RL2]
    else $error("input pin not claimed for external source");

  ext_port_io_a: assert property (ce && clock_source_select == `OSS_SRC_EXT
                                  |=> clock_output_pin.port_owns && !clock_output_pin.oe) // [RL10]
    else $error("output pin not left to port in external clock mode");

  two_edges_a: assert property (engage_s |-> $past(state) == oss_pkg::OSS_ALIGN ##0 confirmed_s) // [RL4]
    else $error("switched without two activity edges");

  switch_low_a: assert property ($changed(using_ext) |-> !full_rate_clock && !$past(full_rate_clock)) // [RL5]
    else $error("source changed while clock high");

  status_first_a: assert property ($rose(int_stopped) |-> $past(ext_clock_engaged)) // [RL6]
    else $error("internal oscillator stopped before status set");

  no_fallback_a: assert property (ext_clock_engaged |=> ext_clock_engaged && using_ext) // [RL7]
    else $error("external clock disengaged without reset");

  half_toggle_a: assert property ($rose(full_rate_clock) |-> $changed(half_rate_clock)) // [RL13]
    else $error("half rate clock missed a full rate edge");

  stop_gates_a: assert property (ce && stop_mode |=> !full_rate_clock) // [RL15]
    else $error("clock runs in stop mode");

  monitor_hold_a: assert property (ce && monitor_bypass && state == oss_pkg::OSS_RUN_INT
                                   |=> state == oss_pkg::OSS_RUN_INT) // [RL18]
    else $error("switch started in monitor bypass");

  enable_gates_a: assert property (ce && !osc_enable_from_integration |=> !full_rate_clock && !rc_osc_enable) // [RL17]
    else $error("oscillator enable ignored");

  sequence enter_confirm_s;
    state == oss_pkg::OSS_RUN_INT ##1 state == oss_pkg::OSS_CONFIRM;
  endsequence

  req_sync_a: assert property (ce |=> req_sync == $past(req_meta)) // [RL23]
    else $error("request synchroniser skipped a stage");

  confirm_entry_a: assert property (enter_confirm_s |-> $past(req_sync) && !$past(monitor_bypass) // [RL23] [RL18]
                                    && $past(clock_source_select) != `OSS_SRC_INT)
    else $error("confirm entered without synchronised request");

  engaged_ext_a: assert property (ext_clock_engaged |-> using_ext) // [RL19]
    else $error("engaged status without external source");

  internal_default_a: assert property (state != oss_pkg::OSS_RUN_EXT |-> !using_ext) // [RL22]
    else $error("external source used before switch completed");

  int_follow_a: assert property (ce && !using_ext && osc_enable_from_integration && !stop_mode // [RL12] [RL22]
                                 |=> full_rate_clock == $past(internal_source_clock))
    else $error("full rate clock does not follow internal source");

  ext_follow_a: assert property (ce && using_ext && osc_enable_from_integration && !stop_mode // [RL11] [RL12]
                                 |=> full_rate_clock == $past(ext_lvl))
    else $error("full rate clock does not follow external source");

  half_hold_a: assert property (!$rose(full_rate_clock) |-> $stable(half_rate_clock)) // [RL13]
    else $error("half rate clock moved without a full rate edge");

  xtal_pin_a: assert property (ce && clock_source_select == `OSS_SRC_XTAL // [RL2] [RL10]
                               |=> xtal_amp_enable && !clock_output_pin.oe && !clock_output_pin.port_owns)
    else $error("output pin not given to crystal amplifier");

  pin_clock_a: assert property (clock_output_pin.oe |-> clock_output_pin.o == full_rate_clock) // [RL10]
    else $error("output pin does not carry full rate clock");

  pin_port_a: assert property (ce && clock_source_select != `OSS_SRC_XTAL && !clkout_pin_enable // [RL10]
                               |=> clock_output_pin.port_owns && !clock_output_pin.oe)
    else $error("output pin not left to port");

  select_lock_a: assert property (state != oss_pkg::OSS_RUN_INT |=> $stable(clock_source_select)) // [RL4]
    else $error("source select changed during switch");

  monitor_request_a: assert property (ce && monitor_bypass |=> $stable(ext_clock_request)) // [RL18]
    else $error("request changed under monitor bypass");

  rc_enable_a: assert property (ce |=> rc_osc_enable == // [RL1] [RL17]
                                ($past(osc_enable_from_integration) && $past(clock_source_select) == `OSS_SRC_RC))
    else $error("rc oscillator enable wrong");

  int_stop_a: assert property (ce && int_stopped |=> !int_osc_enable) // [RL6] [RL7]
    else $error("internal oscillator still enabled after stop");

  int_kept_a: assert property (!ext_clock_engaged |-> !int_stopped) // [RL6]
    else $error("internal oscillator stopped while not engaged");

  trim_write_a: assert property (ce && wr_access && paddr == `OSS_TRIM_OFS // [RL20]
                                 |=> trim_factor == $past(pwdata[7:0]))
    else $error("trim write lost");

endmodule : oss_switch

/* oss_sim_model.sv */
/*
  Partner model: the oscillator circuits and the integration logic around
  the source switch. Assumes the bench drives sim_en and ext_run, and
  that all levels are sampled on pclk.
*/
module oss_sim_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic sim_en,
  input wire logic ext_run,
  // From the switch
  input wire logic int_osc_enable,
  input wire logic rc_osc_enable,
  input wire logic xtal_osc_enable,
  input wire logic full_rate_clock,
  input wire logic half_rate_clock,
  // To the switch
  output logic osc_enable_from_integration,
  output logic internal_source_clock,
  output logic clock_input_pin,
  output logic resistor_cap_clock,
  output logic crystal_source_clock,
  // Edge counts for the bench
  output logic [15:0] full_rises,
  output logic [15:0] half_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] HALF_P [4] = '{4'h3, 4'h4, 4'h5, 4'h6};
  logic [3:0] cnt [4];
  logic [3:0] lvl;
  logic [3:0] run;
  logic last_full, last_half;

  assign osc_enable_from_integration = sim_en;
  // A stopped oscillator sits low; each runs only while enabled
  assign run = {xtal_osc_enable, rc_osc_enable, ext_run, int_osc_enable};
  assign {crystal_source_clock, resistor_cap_clock, clock_input_pin, internal_source_clock} = lvl;

  always_ff @(posedge pclk) begin
    for (int k = 0; k < 4; k++) begin
      if (!run[k]) begin
        lvl[k] <= 1'b0;
        cnt[k] <= 4'h0;
      end else if (cnt[k] == HALF_P[k] - 4'h1) begin
        lvl[k] <= ~lvl[k];
        cnt[k] <= 4'h0;
      end else begin
        cnt[k] <= cnt[k] + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_rises <= 16'h0;
      half_rises <= 16'h0;
      last_full <= 1'b0;
      last_half <= 1'b0;
    end else begin
      last_full <= full_rate_clock;
      last_half <= half_rate_clock;
      full_rises <= full_rises + {15'h0, full_rate_clock & ~last_full};
      half_rises <= half_rises + {15'h0, half_rate_clock & ~last_half};
    end
  end
endmodule : oss_sim_model

/* tb.sv */
/*
  Self-checking bench for the oscillator source switch: APB master,
  partner model and one task per scenario. Assumes oss_sim_model.
*/
`include "oss_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, stop_mode, monitor_bypass, sim_en, ext_run, watch, last_full, rerr;
  logic [`OSS_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [31:0] prdata;
  logic pready, pslverr, internal_source_clock, clock_input_pin, resistor_cap_clock, crystal_source_clock;
  logic osc_enable_from_integration, full_rate_clock, half_rate_clock, int_osc_enable, rc_osc_enable;
  logic xtal_osc_enable, clock_input_enable, xtal_amp_enable;
  logic [7:0] trim_factor;
  logic [15:0] full_rises, half_rises;
  oss_pkg::oss_pin_t clock_output_pin;
  int bad_count, n_checks, hi_run;

  oss_switch uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .internal_source_clock, .clock_input_pin, .resistor_cap_clock, .crystal_source_clock,
    .osc_enable_from_integration, .stop_mode, .monitor_bypass, .full_rate_clock, .half_rate_clock,
    .int_osc_enable, .rc_osc_enable, .xtal_osc_enable, .trim_factor, .clock_input_enable, .xtal_amp_enable,
    .clock_output_pin);
  oss_sim_model partner (.pclk, .presetn, .sim_en, .ext_run, .int_osc_enable, .rc_osc_enable, .xtal_osc_enable,
    .full_rate_clock, .half_rate_clock, .osc_enable_from_integration, .internal_source_clock, .clock_input_pin,
    .resistor_cap_clock, .crystal_source_clock, .full_rises, .half_rises);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [`OSS_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) check(32'h0, 32'h1, "no pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_regs();
    apb(1'b0, `OSS_TRIM_OFS, 32'h0);
    check(rdata, 32'h80, "trim reset");
    apb(1'b0, `OSS_STATUS_OFS, 32'h0);
    check(rdata, 32'h0, "status reset");
    apb(1'b1, `OSS_STATUS_OFS, 32'h1);
    apb(1'b0, `OSS_STATUS_OFS, 32'h0);
    check(rdata, 32'h0, "engaged bit written");
    apb(1'b1, `OSS_TRIM_OFS, 32'hffff_ff3c);
    apb(1'b0, `OSS_TRIM_OFS, 32'h0);
    check(rdata, 32'h3c, "trim readback");
    check(trim_factor, 8'h3c, "trim pins");
    apb(1'b1, 12'h00c, 32'h5);
    check(rerr, 1'b1, "unmapped write");
  endtask : t_regs

  task automatic t_decode();
    logic [1:0] s;
    logic p;
    // Crystal mode entered without precharge, which stays optional
    for (int i = 0; i < 8; i++) begin
      s = i[1:0];
      p = i[2];
      apb(1'b1, `OSS_CTRL_OFS, {29'h0, p, s});
      repeat (3) @(negedge pclk);
      check(clock_input_enable, s != 2'h0, "input pin");
      check(xtal_amp_enable, s == 2'h3, "amp output");
      check({rc_osc_enable, xtal_osc_enable}, {s == 2'h2, s == 2'h3}, "osc enables");
      check({clock_output_pin.oe, clock_output_pin.port_owns}, {p && !s[0], s == 2'h1 || (!s[0] && !p)},
        "output pin");
    end
  endtask : t_decode

  task automatic t_clocks();
    logic prev, h;
    int f0, h0;
    apb(1'b1, `OSS_CTRL_OFS, 32'h4);
    repeat (4) @(negedge pclk);
    f0 = full_rises;
    h0 = half_rises;
    prev = internal_source_clock;
    repeat (60) begin
      @(negedge pclk);
      check(full_rate_clock, prev, "full follows internal");
      check(clock_output_pin.o, prev, "pin carries clock");
      prev = internal_source_clock;
    end
    check((half_rises - h0) * 2 <= full_rises - f0 + 1 && (half_rises - h0) * 2 + 1 >= full_rises - f0, 1'b1,
      "half rate");
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      stop_mode <= (k == 0);
      sim_en <= (k == 0);
      repeat (3) @(negedge pclk);
      h = half_rate_clock;
      check(int_osc_enable, k == 0, "internal enable");
      repeat (20) begin
        @(negedge pclk);
        check({full_rate_clock, half_rate_clock}, {1'b0, h}, "clocks held");
      end
      @(posedge pclk);
      stop_mode <= 1'b0;
      sim_en <= 1'b1;
    end
  endtask : t_clocks

  task automatic t_monitor();
    @(posedge pclk);
    monitor_bypass <= 1'b1;
    apb(1'b1, `OSS_CTRL_OFS, 32'h1);
    apb(1'b1, `OSS_STATUS_OFS, 32'h2);
    apb(1'b0, `OSS_STATUS_OFS, 32'h0);
    check(rdata, 32'h0, "request under monitor");
    @(posedge pclk);
    monitor_bypass <= 1'b0;
  endtask : t_monitor

  task automatic t_switch();
    int n;
    logic prev;
    ext_run <= 1'b1;
    repeat (40) @(posedge pclk);
    watch = 1'b1;
    apb(1'b1, `OSS_STATUS_OFS, 32'h2);
    n = 0;
    do begin
      apb(1'b0, `OSS_STATUS_OFS, 32'h0);
      if (rdata[0] !== 1'b1) check(int_osc_enable, 1'b1, "internal stopped early");
      n++;
    end while (rdata[0] !== 1'b1 && n < 40);
    check(rdata, 32'h3, "engaged");
    check(n >= 2, 1'b1, "engaged too soon");
    repeat (4) @(negedge pclk);
    check(int_osc_enable, 1'b0, "internal still on");
    prev = clock_input_pin;
    repeat (30) begin
      @(negedge pclk);
      check(full_rate_clock, prev, "full follows pin");
      prev = clock_input_pin;
    end
    watch = 1'b0;
    apb(1'b1, `OSS_CTRL_OFS, 32'h0);
    ext_run <= 1'b0;
    repeat (30) @(posedge pclk);
    apb(1'b0, `OSS_STATUS_OFS, 32'h0);
    check({rdata[0], int_osc_enable}, 2'b10, "fallback");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(negedge pclk);
    check(int_osc_enable, 1'b1, "internal after reset");
    apb(1'b0, `OSS_STATUS_OFS, 32'h0);
    check(rdata, 32'h0, "status after reset");
  endtask : t_switch

  // Any high pulse shorter than the internal half period is a glitch
  always @(negedge pclk) begin
    if (full_rate_clock !== last_full) begin
      if (watch && last_full === 1'b1) check(hi_run >= 3, 1'b1, "short pulse");
      hi_run = 0;
    end
    hi_run++;
    last_full = full_rate_clock;
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, stop_mode, monitor_bypass, ext_run, watch} = '0;
    {ce, sim_en} = 2'b11;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_decode();
    t_clocks();
    t_monitor();
    t_switch();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    conclude();
  end
endmodule : tb
